// >>> timer_pkg.sv
package timer_pkg;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CMPA = 8'h08;
    localparam logic [7:0] ADDR_CMPP = 8'h0C;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // timer_control_one field positions; F_ON is the timer_control_zero bit
    localparam int F_MODE_HI = 7;
    localparam int F_MODE_LO = 6;
    localparam int F_PFS_HI = 5;
    localparam int F_PFS_LO = 4;
    localparam int F_OLS = 3;
    localparam int F_INV = 2;
    localparam int F_SWAP = 1;
    localparam int F_CCLR = 0;
    localparam int F_ON = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMPP_RESET = 8'h00;
    localparam logic [15:0] CMPA_RESET = 16'h0000;
    localparam logic [7:0] P_ZERO = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TIMER = 2'h3
    } op_mode_t;

    localparam logic [1:0] PF_0 = 2'h0;
    localparam logic [1:0] PF_1 = 2'h1;
    localparam logic [1:0] PF_2 = 2'h2;
    localparam logic [1:0] PF_3 = 2'h3;
endpackage

// >>> cfg_if.sv
`timescale 1ns/1ps
interface cfg_if;
    import timer_pkg::*;
    logic [1:0] mode;
    logic [1:0] pin_function_select;
    logic output_level_select;
    logic output_invert;
    logic duty_period_swap;
    logic counter_clear_select;
    logic counter_on;
    logic [7:0] comparator_p_value;
    logic [15:0] comparator_a_value;
    logic [15:0] count;
    logic pulse_done;
    logic capture_event;
    logic [15:0] capture_value;
    modport regs (output mode, pin_function_select, output_level_select, output_invert,
        duty_period_swap, counter_clear_select, counter_on, comparator_p_value,
        comparator_a_value, input count, pulse_done, capture_event, capture_value);
    modport core (input mode, pin_function_select, output_level_select, output_invert,
        duty_period_swap, counter_clear_select, counter_on, comparator_p_value,
        comparator_a_value, output count, pulse_done, capture_event, capture_value);
endinterface

// >>> timer_core.sv
`timescale 1ns/1ps
module timer_core
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic capture_input_pin,
    output logic timer_output_pin,
    output logic timer_output_enable,
    cfg_if.core cfg
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic out_level;
    logic next_out_level;
    logic on_d;
    logic cap_d;
    logic [15:0] cap_val;
    logic [15:0] next_cap_val;
    logic cap_ev;
    logic next_cap_ev;
    logic done;
    logic next_done;
    logic match_a;
    logic match_p;
    logic on_rise;
    logic pwm_active;
    logic [16:0] period;
    logic [16:0] duty;
    logic [16:0] p_span;

    // comparator P sees only the upper byte, so matches land on 256-count steps
    assign match_a = cfg.counter_on && (count == cfg.comparator_a_value);
    assign match_p = cfg.counter_on && (count[15:8] == cfg.comparator_p_value)
        && (count[7:0] == P_ZERO) && (cfg.comparator_p_value != P_ZERO);
    assign on_rise = cfg.counter_on && !on_d;
    // P value 0 means a full 65536 span
    assign p_span = (cfg.comparator_p_value == P_ZERO) ? 17'h10000
        : {1'b0, cfg.comparator_p_value, 8'h00};
    assign period = cfg.duty_period_swap ? {1'b0, cfg.comparator_a_value} : p_span;
    assign duty = cfg.duty_period_swap ? p_span : {1'b0, cfg.comparator_a_value};
    assign pwm_active = ({1'b0, count} < duty) || (duty >= period);

    always_comb begin
        next_count = count;
        next_out_level = out_level;
        next_cap_val = cap_val;
        next_cap_ev = 1'b0;
        next_done = done;
        if (on_rise) begin
            next_count = CNT_ZERO;
            next_done = 1'b0;
            if (cfg.mode == MODE_COMPARE) begin
                next_out_level = cfg.output_level_select;
            end
        end else if (cfg.counter_on && !done) begin
            next_count = count + CNT_ONE;
            case (op_mode_t'(cfg.mode))
                MODE_COMPARE, MODE_TIMER: begin
                    // with clear on A, clear and pin change on the same count edge
                    if (cfg.counter_clear_select ? match_a : match_p) begin
                        next_count = CNT_ZERO;
                    end
                    if (match_a && cfg.mode == MODE_COMPARE) begin
                        case (cfg.pin_function_select)
                            PF_1: next_out_level = 1'b0;
                            PF_2: next_out_level = 1'b1;
                            PF_3: next_out_level = !out_level;
                            default: next_out_level = out_level;
                        endcase
                    end
                end
                MODE_PWM: begin
                    // clear select ignored here
                    if (cfg.pin_function_select == PF_3) begin
                        if (match_a) begin
                            next_done = 1'b1;
                        end
                    end else if ({1'b0, count} == period - 17'h00001) begin
                        next_count = CNT_ZERO;
                    end
                end
                MODE_CAPTURE: begin
                    // counter wraps freely while capturing
                    if (count == CNT_MAX) begin
                        next_count = CNT_ZERO;
                    end
                end
                default: next_count = count;
            endcase
        end
        if (cfg.mode == MODE_CAPTURE && cfg.pin_function_select != PF_3) begin
            case (cfg.pin_function_select)
                PF_0: next_cap_ev = capture_input_pin && !cap_d;
                PF_1: next_cap_ev = !capture_input_pin && cap_d;
                PF_2: next_cap_ev = capture_input_pin != cap_d;
                default: next_cap_ev = 1'b0;
            endcase
            if (next_cap_ev) begin
                next_cap_val = count;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= CNT_ZERO;
            out_level <= 1'b0;
            on_d <= 1'b0;
            cap_d <= 1'b0;
            cap_val <= CNT_ZERO;
            cap_ev <= 1'b0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            out_level <= next_out_level;
            on_d <= cfg.counter_on;
            cap_d <= capture_input_pin;
            cap_val <= next_cap_val;
            cap_ev <= next_cap_ev;
            done <= next_done;
        end
    end

    logic pin_raw;
    always_comb begin
        pin_raw = out_level;
        if (cfg.mode == MODE_PWM) begin
            case (cfg.pin_function_select)
                PF_0: pin_raw = !cfg.output_level_select;
                PF_1: pin_raw = cfg.output_level_select;
                PF_2: pin_raw = pwm_active ~^ cfg.output_level_select;
                default: pin_raw = (cfg.counter_on && !done) ~^ cfg.output_level_select;
            endcase
        end
    end

    logic pin_q;
    logic next_pin_q;
    always_comb begin
        next_pin_q = pin_raw ^ cfg.output_invert;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= next_pin_q;
        end
    end

    // timer/counter and capture modes release the pin
    assign timer_output_pin = pin_q;
    assign timer_output_enable = (cfg.mode == MODE_COMPARE) || (cfg.mode == MODE_PWM);
    assign cfg.count = count;
    assign cfg.pulse_done = done;
    assign cfg.capture_event = cap_ev;
    assign cfg.capture_value = cap_val;
endmodule

// >>> timer_output_compare_control.sv
`timescale 1ns/1ps
module timer_output_compare_control
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_input_pin,
    output logic timer_output_pin,
    output logic timer_output_enable
);
    cfg_if cfg();

    logic [7:0] timer_control_zero;
    logic [7:0] next_timer_control_zero;
    logic [7:0] timer_control_one;
    logic [7:0] next_timer_control_one;
    logic [15:0] cmpa;
    logic [15:0] next_cmpa;
    logic [7:0] period_compare_high_byte;
    logic [7:0] next_period_compare_high_byte;
    logic [31:0] next_prdata;
    logic capture_seen;
    logic next_capture_seen;

    function automatic logic addr_known(input logic [7:0] a);
        return a == ADDR_CTRL0 || a == ADDR_CTRL1 || a == ADDR_CMPA
            || a == ADDR_CMPP || a == ADDR_COUNT || a == ADDR_STATUS;
    endfunction

    logic wr;
    logic rd;
    logic rd_setup;
    logic done_d;
    logic next_done_d;
    assign wr = psel && penable && pwrite && addr_known(paddr);
    assign rd = psel && penable && !pwrite;
    // read data loaded in setup so it already stands when pready is sampled
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_known(paddr);

    always_comb begin
        next_timer_control_zero = timer_control_zero;
        next_timer_control_one = timer_control_one;
        next_cmpa = cmpa;
        next_period_compare_high_byte = period_compare_high_byte;
        next_prdata = prdata;
        next_capture_seen = capture_seen || cfg.capture_event;
        next_done_d = cfg.pulse_done;
        if (cfg.pulse_done && !done_d) begin
            // only the end of the pulse drops counter on; a stale done flag
            // must not undo a restart
            next_timer_control_zero[F_ON] = 1'b0;
        end
        if (wr) begin
            case (paddr)
                ADDR_CTRL0: next_timer_control_zero = {7'h00, pwdata[F_ON]};
                ADDR_CTRL1: next_timer_control_one = pwdata[7:0];
                ADDR_CMPA: next_cmpa = pwdata[15:0];
                ADDR_CMPP: next_period_compare_high_byte = pwdata[7:0];
                default: next_cmpa = cmpa;
            endcase
        end
        if (rd_setup) begin
            case (paddr)
                ADDR_CTRL0: next_prdata = {24'h000000, timer_control_zero};
                ADDR_CTRL1: next_prdata = {24'h000000, timer_control_one};
                ADDR_CMPA: next_prdata = {16'h0000, cmpa};
                ADDR_CMPP: next_prdata = {24'h000000, period_compare_high_byte};
                ADDR_COUNT: next_prdata = {16'h0000, cfg.count};
                ADDR_STATUS: next_prdata = {cfg.capture_value, 14'h0000,
                    cfg.pulse_done, capture_seen};
                default: next_prdata = 32'h00000000;
            endcase
        end
        // status read clears only the flag it reported; a new event still wins
        if (rd && paddr == ADDR_STATUS) begin
            next_capture_seen = (capture_seen && !prdata[0]) || cfg.capture_event;
        end
    end

    // register values feed the core combinationally; bus read data is registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_zero <= CTRL_RESET;
            timer_control_one <= CTRL_RESET;
            cmpa <= CMPA_RESET;
            period_compare_high_byte <= CMPP_RESET;
            prdata <= 32'h00000000;
            capture_seen <= 1'b0;
            done_d <= 1'b0;
        end else begin
            timer_control_zero <= next_timer_control_zero;
            timer_control_one <= next_timer_control_one;
            cmpa <= next_cmpa;
            period_compare_high_byte <= next_period_compare_high_byte;
            prdata <= next_prdata;
            capture_seen <= next_capture_seen;
            done_d <= next_done_d;
        end
    end

    assign cfg.mode = timer_control_one[F_MODE_HI:F_MODE_LO];
    assign cfg.pin_function_select = timer_control_one[F_PFS_HI:F_PFS_LO];
    assign cfg.output_level_select = timer_control_one[F_OLS];
    assign cfg.output_invert = timer_control_one[F_INV];
    assign cfg.duty_period_swap = timer_control_one[F_SWAP];
    assign cfg.counter_clear_select = timer_control_one[F_CCLR];
    assign cfg.counter_on = timer_control_zero[F_ON];
    assign cfg.comparator_p_value = period_compare_high_byte;
    assign cfg.comparator_a_value = cmpa;

    timer_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .capture_input_pin(capture_input_pin),
        .timer_output_pin(timer_output_pin),
        .timer_output_enable(timer_output_enable),
        .cfg(cfg)
    );
endmodule

// >>> timer_output_compare_control_monitor.sv
`timescale 1ns/1ps
module timer_output_compare_control_monitor
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic timer_output_pin,
    input wire logic timer_output_enable
);
    // shadows of software writes; the single-pulse self stop is not tracked
    logic wr, rd, on, next_on;
    logic [7:0] ctrl1, cmpp, next_ctrl1, next_cmpp;
    logic [15:0] cmpa, next_cmpa;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    always_comb begin
        next_on = (wr && paddr == ADDR_CTRL0) ? pwdata[F_ON] : on;
        next_ctrl1 = (wr && paddr == ADDR_CTRL1) ? pwdata[7:0] : ctrl1;
        next_cmpp = (wr && paddr == ADDR_CMPP) ? pwdata[7:0] : cmpp;
        next_cmpa = (wr && paddr == ADDR_CMPA) ? pwdata[15:0] : cmpa;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {on, ctrl1, cmpp, cmpa} <= 33'h0;
        end else begin
            {on, ctrl1, cmpp, cmpa} <= {next_on, next_ctrl1, next_cmpp, next_cmpa};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_err; psel && penable && paddr > ADDR_STATUS |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped access");
    property p_err_ph; pslverr |-> psel && penable; endproperty
    a_err_ph: assert property (p_err_ph) else $error("error outside access phase");
    property p_oe; timer_output_enable == !ctrl1[F_MODE_LO]; endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong for mode");
    property p_rd_ctrl1; rd && paddr == ADDR_CTRL1 |-> prdata == {24'h0, ctrl1};
    endproperty
    a_rd_ctrl1: assert property (p_rd_ctrl1) else $error("control readback wrong");
    property p_rd_cmpp; rd && paddr == ADDR_CMPP |-> prdata == {24'h0, cmpp};
    endproperty
    a_rd_cmpp: assert property (p_rd_cmpp) else $error("period byte readback wrong");
    property p_rd_cmpa; rd && paddr == ADDR_CMPA |-> prdata == {16'h0, cmpa};
    endproperty
    a_rd_cmpa: assert property (p_rd_cmpa) else $error("compare A readback wrong");
    property p_force;
        (!wr)[*3] ##0 (ctrl1[7:6] == 2'h2 && !ctrl1[F_PFS_HI])
            |-> timer_output_pin == ((ctrl1[F_PFS_LO] ~^ ctrl1[F_OLS]) ^ ctrl1[F_INV]);
    endproperty
    a_force: assert property (p_force) else $error("forced level wrong");
    // compare A kept clear of the first counts so no match races the restore
    property p_restore;
        wr && paddr == ADDR_CTRL0 && pwdata[F_ON] && !on && ctrl1[7:6] == 2'h0 && cmpa > 16'h4
            |-> ##[1:3] timer_output_pin == (ctrl1[F_OLS] ^ ctrl1[F_INV]);
    endproperty
    a_restore: assert property (p_restore) else $error("no restore on start");
    c_restore: cover property (p_restore);
    c_force: cover property (p_force);
    c_err: cover property (psel && penable && pslverr);
endmodule
bind timer_output_compare_control timer_output_compare_control_monitor mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .timer_output_pin(timer_output_pin),
    .timer_output_enable(timer_output_enable));

// >>> pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
    input wire logic level_req,
    input wire logic timer_output_pin,
    input wire logic timer_output_enable,
    output logic capture_input_pin,
    output logic pin_seen
);
    logic last = 1'b0;
    assign capture_input_pin = level_req;
    // a released pin shows the opposite of its last level, never a stale copy
    always @(timer_output_pin or timer_output_enable)
        if (timer_output_enable) last = timer_output_pin;
    assign pin_seen = timer_output_enable ? timer_output_pin : !last;
endmodule

// >>> timer_output_compare_control_test.sv
`timescale 1ns/1ps
module timer_output_compare_control_test;
    import timer_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic cap_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pin, oe, cap_pin, pin_seen, err;
    int err_total = 0;
    int n_compared = 0;
    int hi;
    timer_output_compare_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_input_pin(cap_pin),
        .timer_output_pin(pin), .timer_output_enable(oe));
    pin_partner pins (.level_req(cap_req), .timer_output_pin(pin), .timer_output_enable(oe),
        .capture_input_pin(cap_pin), .pin_seen(pin_seen));
    initial forever #50 pclk = ~pclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // read data stands from the setup edge, so it is taken at the access edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
        if (pready !== 1'b1) err_total++;
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run_hi(input logic [7:0] c, input int n);
        apb(1'b1, ADDR_CTRL0, 32'h0);
        apb(1'b1, ADDR_CTRL1, {24'h0, c});
        apb(1'b1, ADDR_CTRL0, 32'h1);
        hi = 0;
        // pin sampled mid-cycle, away from the edge that launches it
        repeat (n) begin
            @(negedge pclk);
            hi += pin_seen;
        end
        @(posedge pclk);
    endtask
    task automatic t_regs();
        apb(1'b0, ADDR_CMPP, 32'h0);
        chk("cmpp reset", 32'h0, rd);
        apb(1'b0, ADDR_CTRL1, 32'h0);
        chk("ctrl1 reset", 32'h0, rd);
        chk("reset enable", 1, oe);
        apb(1'b1, ADDR_CTRL1, 32'hFFFF_FFA5);
        apb(1'b0, ADDR_CTRL1, 32'h0);
        chk("ctrl1 rw", 32'hA5, rd);
        apb(1'b1, ADDR_CMPP, 32'h0000_01C3);
        apb(1'b0, ADDR_CMPP, 32'h0);
        chk("cmpp rw", 32'hC3, rd);
        apb(1'b1, 8'h40, 32'h1);
        chk("unmapped", 1, err);
        run_hi(8'hC0, 4);
        chk("timer mode enable", 0, oe);
    endtask
    task automatic t_compare();
        logic [1:0] pf;
        logic ol, iv, lv;
        // above 255 so an 8-bit-only compare would hit early
        apb(1'b1, ADDR_CMPA, 32'h120);
        apb(1'b1, ADDR_CMPP, 32'h0);
        for (int i = 0; i < 16; i++) begin
            {iv, ol, pf} = i[3:0];
            lv = (pf == PF_0) ? ol : (pf == PF_3) ? !ol : pf[1];
            run_hi({2'h0, pf, ol, iv, 2'h0}, 100);
            chk("before match", ol ^ iv, hi > 50);
            repeat (250) @(posedge pclk);
            chk("after match", lv ^ iv, pin_seen);
        end
    endtask
    task automatic t_clear();
        apb(1'b1, ADDR_CMPA, 32'h20);
        run_hi(8'h01, 100);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("clear on A", 1, rd < 32'h21);
        apb(1'b1, ADDR_CMPP, 32'h1);
        run_hi(8'h00, 600);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("clear on P", 1, rd < 32'h101);
        apb(1'b1, ADDR_CMPP, 32'h2);
        run_hi(8'h00, 400);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("P period 512", 1, rd > 32'h100 && rd < 32'h201);
    endtask
    task automatic t_pwm();
        for (int i = 0; i < 8; i++) begin
            run_hi({2'h2, 1'b0, i[0], i[1], i[2], 2'h0}, 512);
            chk("forced", (!(i[0] ^ i[1]) ^ i[2]) ? 32'h200 : 32'h0, hi);
        end
        apb(1'b1, ADDR_CMPP, 32'h1);
        apb(1'b1, ADDR_CMPA, 32'h80);
        apb(1'b0, ADDR_CMPA, 32'h0);
        chk("cmpa rw", 32'h80, rd);
        run_hi(8'hA9, 512);
        chk("pwm duty", 1, hi inside {[250:262]});
        run_hi(8'hAB, 512);
        chk("full duty", 1, hi > 505);
        // second pulse checks that a restart is not cut short
        repeat (2) begin
            run_hi(8'hB8, 512);
            chk("pulse width", 1, hi inside {[124:132]});
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("pulse done", 1, rd[1]);
        apb(1'b0, ADDR_CTRL0, 32'h0);
        chk("pulse self stop", 0, rd);
    endtask
    task automatic t_capture();
        logic [3:0] re, fe;
        re = 4'h5;
        fe = 4'h6;
        for (int i = 0; i < 4; i++) begin
            run_hi({2'h1, i[1:0], 4'h0}, 4);
            apb(1'b0, ADDR_STATUS, 32'h0);
            cap_req <= 1'b1;
            repeat (4) @(posedge pclk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("rise capture", re[i], rd[0]);
            cap_req <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("fall capture", fe[i], rd[0]);
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_compare();
        t_clear();
        t_pwm();
        t_capture();
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        print_verdict();
    end
endmodule
